// ---- logic/core_cfg.svh ----
// constants of the core state datapath
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH
`define REG_COUNT 32
`define IO_COUNT 64
`define IO_BASE 16'h0020
`define SRAM_BASE 16'h0060
`define IO_STATUS 6'h3f
`define IO_STACK_HI 6'h3e
`define IO_STACK_LO 6'h3d
`define FLAG_I 7
`define FLAG_T 6
`define FLAG_H 5
`define FLAG_S 4
`define FLAG_V 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0
`define STATUS_RESET 8'h00
`define SP_RESET 16'h0000
`define PC_RESET 16'h0000
`define VEC_STRIDE 16'h0002
`define PTR_BASE 5'h1a
`endif

// ---- logic/core_pkg.sv ----
// types of the core state datapath
package core_pkg;
	typedef enum logic [4:0] {
		OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR, OP_COM, OP_MOV, OP_LDI,
		OP_MUL, OP_ADIW, OP_SBIW, OP_MOVW, OP_BIT_STORE, OP_BIT_LOAD, OP_SEI, OP_CLI, OP_IN, OP_OUT,
		OP_LD, OP_ST, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_IRQ_RETURN, OP_JMP
	} op_t;
	typedef enum logic [1:0] {PTR_PLAIN, PTR_POSTINC, PTR_PREDEC, PTR_DISP} ptr_mode_t;
	typedef enum logic [1:0] {ST_RUN, ST_PUSH_HI, ST_POP_LO} state_t;
endpackage

// ---- logic/cpu_core_state_datapath.sv ----
// fetch pipeline, register file, status flags and stack of an 8-bit core
// Overview of operation
// - next instruction is fetched while current one executes, one per clock
// - thirty-two 8-bit registers, each readable and writable in one clock
// - two operands read, result computed and written back in one clock
// - port schemes 8->8, 8+8->8, 8+8->16 and 16->16
// - top six registers form three 16-bit pointers with displacement, increment, decrement
// - registers appear as the lowest 32 data-space addresses
// - 64 I/O addresses, reached directly or right after the register file
// - bit 7 enables interrupts; cleared on entry, set by interrupt return, set/clear instructions
// - bit 6 is a one-bit store for bit copy instructions
// - bit 5 records carry out of the low nibble
// - bit 4 always equals negative xor overflow
// - bit 3 flags two's complement overflow
// - bit 2 flags negative result, bit 1 flags zero result
// - bit 0 flags carry
// - status updated after every ALU operation
// - status neither saved on interrupt entry nor restored on return
// - lower vector index wins among pending interrupts
// - stack grows downward, pointer addresses top, push lowers it
// - byte push decrements pointer by one, pop increments by one
// - calls and interrupt entry push address, minus two; returns pop, plus two
// - stack pointer lives in two 8-bit I/O registers; high byte may be absent
`timescale 1ns/10ps
`include "core_cfg.svh"
module cpu_core_state_datapath #(
	parameter int SP_WIDTH = 16,
	parameter int IRQ_COUNT = 20
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// program memory
	output logic [15:0] prog_addr,
	input wire logic [15:0] prog_data,
	// instruction to decoder
	output logic [15:0] instr_word,
	output logic [15:0] instr_pc,
	output logic instr_valid,
	output logic busy,
	// decoded operation
	input wire core_pkg::op_t op,
	input wire logic [4:0] rd_idx,
	input wire logic [4:0] rr_idx,
	input wire logic [7:0] imm,
	input wire logic [2:0] bit_sel,
	input wire logic [1:0] ptr_sel,
	input wire core_pkg::ptr_mode_t ptr_mode,
	input wire logic [15:0] target,
	// data sram
	output logic [15:0] dmem_addr,
	output logic [7:0] dmem_wdata,
	output logic dmem_we,
	output logic dmem_re,
	input wire logic [7:0] dmem_rdata,
	// peripheral i/o
	output logic [5:0] io_addr,
	output logic [7:0] io_wdata,
	output logic io_we,
	output logic io_re,
	input wire logic [7:0] io_rdata,
	// interrupts
	input wire logic [IRQ_COUNT-1:0] irq_req,
	output logic irq_ack,
	output logic [4:0] irq_ack_idx,
	// state
	output logic [7:0] status_flags_register,
	output logic [15:0] stack_pointer
);
	generate
		if (SP_WIDTH < 8 || SP_WIDTH > 16 || IRQ_COUNT < 1 || IRQ_COUNT > 32) begin : g_bad
			$error("unsupported SP_WIDTH or IRQ_COUNT");
		end
	endgenerate

	logic [7:0] regs_q [`REG_COUNT];
	logic [15:0] pc_q, pc_d, instr_q, exec_pc_q, hold_q, hold_d, jump_q, jump_d;
	logic valid_q, flush, take_irq;
	logic [7:0] stat_q, stat_d;
	logic [SP_WIDTH-1:0] sp_q, sp_d;
	core_pkg::state_t state_q, state_d;
	logic wr8_en, wr16_en;
	logic [4:0] wr8_idx, irq_idx;
	logic [3:0] wr16_idx;
	logic [7:0] wr8_val, a, b, bb, r8, dread, dwrite;
	logic [15:0] wr16_val, pa, pb, ptr, eff, r16;
	logic [8:0] sum9;
	logic [4:0] h5;
	logic cx, sub, ds_rd, ds_wr;
	logic [5:0] io_idx;

	function automatic logic [7:0] flags(input logic [7:0] s, input logic h, input logic v, input logic n,
		input logic z, input logic c);
		flags = {s[`FLAG_I], s[`FLAG_T], h, n ^ v, v, n, z, c};
	endfunction

	assign prog_addr = pc_q;
	assign instr_word = instr_q;
	assign instr_pc = exec_pc_q;
	assign instr_valid = valid_q;
	assign busy = state_q != core_pkg::ST_RUN;
	assign status_flags_register = stat_q;
	assign stack_pointer = 16'(sp_q);

	// lowest pending index wins
	always_comb begin
		irq_idx = 5'h00;
		for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
			if (irq_req[i]) begin
				irq_idx = 5'(i);
			end
		end
	end
	assign take_irq = stat_q[`FLAG_I] && (|irq_req) && valid_q && state_q == core_pkg::ST_RUN;

	// operands and pointer
	always_comb begin
		a = regs_q[rd_idx];
		b = (op == core_pkg::OP_LDI) ? imm : regs_q[rr_idx];
		pa = {regs_q[{rd_idx[4:1], 1'b1}], regs_q[{rd_idx[4:1], 1'b0}]};
		pb = {regs_q[{rr_idx[4:1], 1'b1}], regs_q[{rr_idx[4:1], 1'b0}]};
		ptr = {regs_q[`PTR_BASE + {2'b00, ptr_sel, 1'b1}], regs_q[`PTR_BASE + {2'b00, ptr_sel, 1'b0}]};
		sub = op == core_pkg::OP_SUB || op == core_pkg::OP_SBC;
		cx = (op == core_pkg::OP_ADC || op == core_pkg::OP_SBC) ? stat_q[`FLAG_C] : 1'b0;
		cx = sub ? ~cx : cx;
		bb = sub ? ~b : b;
		sum9 = {1'b0, a} + {1'b0, bb} + {8'h00, cx};
		h5 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cx};
		unique case (ptr_mode)
			core_pkg::PTR_PREDEC: eff = ptr - 16'h0001;
			core_pkg::PTR_DISP: eff = ptr + {10'h000, imm[5:0]};
			default: eff = ptr;
		endcase
		if (op == core_pkg::OP_IN || op == core_pkg::OP_OUT) begin
			eff = `IO_BASE + {10'h000, imm[5:0]};
		end
	end

	// data-space read and write decode
	always_comb begin
		io_idx = 6'(eff - `IO_BASE);
		ds_rd = (op == core_pkg::OP_LD || op == core_pkg::OP_IN) && valid_q && !take_irq;
		ds_wr = (op == core_pkg::OP_ST || op == core_pkg::OP_OUT) && valid_q && !take_irq;
		dwrite = regs_q[rd_idx];
		io_addr = io_idx;
		io_wdata = dwrite;
		io_we = 1'b0;
		io_re = 1'b0;
		dread = 8'h00;
		if (eff < `IO_BASE) begin
			dread = regs_q[eff[4:0]];
		end else if (eff < `SRAM_BASE) begin
			if (io_idx == `IO_STATUS) begin
				dread = stat_q;
			end else if (io_idx == `IO_STACK_LO) begin
				dread = sp_q[7:0];
			end else if (io_idx == `IO_STACK_HI) begin
				dread = 8'(16'(sp_q) >> 8);
			end else begin
				dread = io_rdata;
				io_re = ds_rd && state_q == core_pkg::ST_RUN;
				io_we = ds_wr && state_q == core_pkg::ST_RUN;
			end
		end
	end

	// execute
	always_comb begin
		pc_d = pc_q + 16'h0001;
		flush = 1'b0;
		state_d = core_pkg::ST_RUN;
		stat_d = stat_q;
		sp_d = sp_q;
		hold_d = hold_q;
		jump_d = jump_q;
		wr8_en = 1'b0;
		wr8_idx = rd_idx;
		wr8_val = 8'h00;
		wr16_en = 1'b0;
		wr16_idx = rd_idx[4:1];
		wr16_val = 16'h0000;
		r8 = 8'h00;
		r16 = 16'h0000;
		dmem_addr = eff;
		dmem_wdata = dwrite;
		dmem_we = 1'b0;
		dmem_re = 1'b0;
		irq_ack = 1'b0;
		irq_ack_idx = irq_idx;
		unique case (state_q)
			core_pkg::ST_PUSH_HI: begin
				pc_d = pc_q;
				dmem_addr = 16'(sp_q);
				dmem_wdata = hold_q[15:8];
				dmem_we = 1'b1;
				sp_d = sp_q - 1'b1;
				pc_d = jump_q;
				flush = 1'b1;
			end
			core_pkg::ST_POP_LO: begin
				sp_d = sp_q + 1'b1;
				dmem_addr = 16'(sp_d);
				dmem_re = 1'b1;
				pc_d = {hold_q[15:8], dmem_rdata};
				flush = 1'b1;
			end
			default: begin
				if (take_irq) begin
					// pushes the address of the squashed instruction; status left alone except bit 7, which is cleared
					irq_ack = 1'b1;
					stat_d[`FLAG_I] = 1'b0;
					hold_d = exec_pc_q;
					jump_d = `VEC_STRIDE * (16'(irq_idx) + 16'h0001);
					dmem_addr = 16'(sp_q);
					dmem_wdata = exec_pc_q[7:0];
					dmem_we = 1'b1;
					sp_d = sp_q - 1'b1;
					pc_d = pc_q;
					state_d = core_pkg::ST_PUSH_HI;
				end else if (valid_q) begin
					unique case (op)
						core_pkg::OP_ADD, core_pkg::OP_ADC, core_pkg::OP_SUB, core_pkg::OP_SBC: begin
							r8 = sum9[7:0];
							wr8_en = 1'b1;
							wr8_val = r8;
							stat_d = flags(stat_q, sub ^ h5[4], (a[7] == bb[7]) && (r8[7] != a[7]), r8[7],
								r8 == 8'h00, sub ^ sum9[8]);
						end
						core_pkg::OP_AND, core_pkg::OP_OR, core_pkg::OP_EOR: begin
							r8 = (op == core_pkg::OP_AND) ? (a & b) : (op == core_pkg::OP_OR) ? (a | b) : (a ^ b);
							wr8_en = 1'b1;
							wr8_val = r8;
							stat_d = flags(stat_q, stat_q[`FLAG_H], 1'b0, r8[7], r8 == 8'h00, stat_q[`FLAG_C]);
						end
						core_pkg::OP_COM: begin
							r8 = ~a;
							wr8_en = 1'b1;
							wr8_val = r8;
							stat_d = flags(stat_q, stat_q[`FLAG_H], 1'b0, r8[7], r8 == 8'h00, 1'b1);
						end
						core_pkg::OP_MOV, core_pkg::OP_LDI: begin
							wr8_en = 1'b1;
							wr8_val = b;
						end
						core_pkg::OP_MUL: begin
							r16 = {8'h00, a} * {8'h00, b};
							wr16_en = 1'b1;
							wr16_idx = 4'h0;
							wr16_val = r16;
							stat_d = flags(stat_q, stat_q[`FLAG_H], stat_q[`FLAG_V], stat_q[`FLAG_N], r16 == 16'h0000,
								r16[15]);
						end
						core_pkg::OP_ADIW, core_pkg::OP_SBIW: begin
							r16 = (op == core_pkg::OP_ADIW) ? pa + {10'h000, imm[5:0]} : pa - {10'h000, imm[5:0]};
							wr16_en = 1'b1;
							wr16_val = r16;
							stat_d = flags(stat_q, stat_q[`FLAG_H], (op == core_pkg::OP_ADIW) ? (~pa[15] & r16[15]) :
								(pa[15] & ~r16[15]), r16[15], r16 == 16'h0000, (op == core_pkg::OP_ADIW) ?
								(pa[15] & ~r16[15]) : (~pa[15] & r16[15]));
						end
						core_pkg::OP_MOVW: begin
							wr16_en = 1'b1;
							wr16_val = pb;
						end
						core_pkg::OP_BIT_STORE: stat_d[`FLAG_T] = a[bit_sel];
						core_pkg::OP_BIT_LOAD: begin
							wr8_en = 1'b1;
							wr8_val = a;
							wr8_val[bit_sel] = stat_q[`FLAG_T];
						end
						core_pkg::OP_SEI: stat_d[`FLAG_I] = 1'b1;
						core_pkg::OP_CLI: stat_d[`FLAG_I] = 1'b0;
						core_pkg::OP_IN, core_pkg::OP_LD: begin
							dmem_re = eff >= `SRAM_BASE;
							wr8_en = 1'b1;
							wr8_val = (eff >= `SRAM_BASE) ? dmem_rdata : dread;
							if (op == core_pkg::OP_LD && ptr_mode != core_pkg::PTR_PLAIN && ptr_mode != core_pkg::PTR_DISP) begin
								wr16_en = 1'b1;
								wr16_idx = {2'b11, ptr_sel} + 4'h1;
								wr16_val = (ptr_mode == core_pkg::PTR_POSTINC) ? ptr + 16'h0001 : eff;
							end
						end
						core_pkg::OP_OUT, core_pkg::OP_ST: begin
							dmem_we = eff >= `SRAM_BASE;
							if (eff < `IO_BASE) begin
								wr8_en = 1'b1;
								wr8_idx = eff[4:0];
								wr8_val = dwrite;
							end else if (eff < `SRAM_BASE && io_idx == `IO_STATUS) begin
								stat_d = {dwrite[7:5], dwrite[2] ^ dwrite[3], dwrite[3:0]};
							end else if (eff < `SRAM_BASE && io_idx == `IO_STACK_LO) begin
								sp_d[7:0] = dwrite;
							end else if (eff < `SRAM_BASE && io_idx == `IO_STACK_HI) begin
								sp_d = SP_WIDTH'({dwrite, sp_q[7:0]});
							end
							if (op == core_pkg::OP_ST && ptr_mode != core_pkg::PTR_PLAIN && ptr_mode != core_pkg::PTR_DISP) begin
								wr16_en = 1'b1;
								wr16_idx = {2'b11, ptr_sel} + 4'h1;
								wr16_val = (ptr_mode == core_pkg::PTR_POSTINC) ? ptr + 16'h0001 : eff;
							end
						end
						core_pkg::OP_PUSH: begin
							dmem_addr = 16'(sp_q);
							dmem_we = 1'b1;
							sp_d = sp_q - 1'b1;
						end
						core_pkg::OP_POP: begin
							sp_d = sp_q + 1'b1;
							dmem_addr = 16'(sp_d);
							dmem_re = 1'b1;
							wr8_en = 1'b1;
							wr8_val = dmem_rdata;
						end
						core_pkg::OP_CALL: begin
							hold_d = exec_pc_q + 16'h0001;
							jump_d = target;
							dmem_addr = 16'(sp_q);
							dmem_wdata = hold_d[7:0];
							dmem_we = 1'b1;
							sp_d = sp_q - 1'b1;
							pc_d = pc_q;
							state_d = core_pkg::ST_PUSH_HI;
						end
						core_pkg::OP_RET, core_pkg::OP_IRQ_RETURN: begin
							sp_d = sp_q + 1'b1;
							dmem_addr = 16'(sp_d);
							dmem_re = 1'b1;
							hold_d = {dmem_rdata, 8'h00};
							if (op == core_pkg::OP_IRQ_RETURN) begin
								stat_d[`FLAG_I] = 1'b1;
							end
							pc_d = pc_q;
							state_d = core_pkg::ST_POP_LO;
						end
						core_pkg::OP_JMP: begin
							pc_d = target;
							flush = 1'b1;
						end
						default: ;
					endcase
				end
			end
		endcase
	end

	// fetch pipeline
	always_ff @(posedge clock) begin
		if (rst) begin
			pc_q <= `PC_RESET;
			instr_q <= 16'h0000;
			exec_pc_q <= 16'h0000;
			valid_q <= 1'b0;
		end else begin
			pc_q <= pc_d;
			instr_q <= prog_data;
			exec_pc_q <= pc_q;
			valid_q <= !flush && state_d == core_pkg::ST_RUN;
		end
	end

	// control state
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= core_pkg::ST_RUN;
			stat_q <= `STATUS_RESET;
			sp_q <= SP_WIDTH'(`SP_RESET);
			hold_q <= 16'h0000;
			jump_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			stat_q <= stat_d;
			sp_q <= sp_d;
			hold_q <= hold_d;
			jump_q <= jump_d;
		end
	end

	// register file, pair port then byte port
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int i = 0; i < `REG_COUNT; i++) begin
				regs_q[i] <= 8'h00;
			end
		end else begin
			if (wr16_en) begin
				regs_q[{wr16_idx, 1'b0}] <= wr16_val[7:0];
				regs_q[{wr16_idx, 1'b1}] <= wr16_val[15:8];
			end
			if (wr8_en) begin
				regs_q[wr8_idx] <= wr8_val;
			end
		end
	end
endmodule

// ---- dv/cpu_core_state_datapath_properties.sv ----
// port assertions of the core state datapath
`timescale 1ns/10ps
module cpu_core_state_datapath_properties #(
	parameter int IRQ_COUNT = 20
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// instruction stream
	input wire logic instr_valid,
	input wire logic busy,
	input wire logic [15:0] instr_pc,
	input wire core_pkg::op_t op,
	// interrupts
	input wire logic [IRQ_COUNT-1:0] irq_req,
	input wire logic irq_ack,
	input wire logic [4:0] irq_ack_idx,
	// state and sram
	input wire logic [7:0] status_flags_register,
	input wire logic [15:0] stack_pointer,
	input wire logic dmem_we,
	input wire logic [15:0] dmem_addr
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic go;
	logic [IRQ_COUNT-1:0] below;
	assign go = instr_valid && !busy && !irq_ack;
	assign below = (IRQ_COUNT'(1) << irq_ack_idx) - IRQ_COUNT'(1);
	property p_nop_step;
		go && op == core_pkg::OP_NOP |=> instr_valid && instr_pc == $past(instr_pc) + 16'h0001;
	endproperty
	a_nop_step: assert property (p_nop_step) else $error("fetch did not advance");
	property p_push;
		go && op == core_pkg::OP_PUSH |-> dmem_we && dmem_addr == stack_pointer
			##1 stack_pointer == $past(stack_pointer) - 16'h0001;
	endproperty
	a_push: assert property (p_push) else $error("push wrong");
	property p_pop;
		go && op == core_pkg::OP_POP |=> stack_pointer == $past(stack_pointer) + 16'h0001;
	endproperty
	a_pop: assert property (p_pop) else $error("pop wrong");
	property p_call;
		go && op == core_pkg::OP_CALL |=> busy ##1 stack_pointer == $past(stack_pointer, 2) - 16'h0002;
	endproperty
	a_call: assert property (p_call) else $error("call stack wrong");
	property p_irq_gate;
		irq_ack |-> status_flags_register[7] ##1 !status_flags_register[7];
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("enable bit wrong on entry");
	property p_irq_keep;
		irq_ack |=> (status_flags_register & 8'h7f) == ($past(status_flags_register) & 8'h7f);
	endproperty
	a_irq_keep: assert property (p_irq_keep) else $error("status touched on entry");
	property p_prio;
		irq_ack |-> irq_req[irq_ack_idx] && (irq_req & below) == '0;
	endproperty
	a_prio: assert property (p_prio) else $error("wrong interrupt taken");
	property p_irq_return;
		go && op == core_pkg::OP_IRQ_RETURN |=> status_flags_register[7];
	endproperty
	a_irq_return: assert property (p_irq_return) else $error("return left enable clear");
	property p_sign;
		status_flags_register[4] == (status_flags_register[2] ^ status_flags_register[3]);
	endproperty
	a_sign: assert property (p_sign) else $error("sign bit mismatch");
endmodule
bind cpu_core_state_datapath cpu_core_state_datapath_properties #(.IRQ_COUNT(IRQ_COUNT)) props (.clock, .rst,
	.instr_valid, .busy, .instr_pc, .op, .irq_req, .irq_ack, .irq_ack_idx, .status_flags_register,
	.stack_pointer, .dmem_we, .dmem_addr);

// ---- dv/core_mem_model.sv ----
// program flash and data sram beside the core
`timescale 1ns/10ps
module core_mem_model (
	// clock
	input wire logic clock,
	// program flash
	input wire logic [15:0] prog_addr,
	output logic [15:0] prog_data,
	// data sram
	input wire logic [15:0] dmem_addr,
	input wire logic [7:0] dmem_wdata,
	input wire logic dmem_we,
	input wire logic dmem_re,
	output logic [7:0] dmem_rdata
);
	logic [7:0] mem [0:1023];
	logic [7:0] last_q = 8'h00;
	assign prog_data = ~prog_addr;
	// released bus shows the inverse of the last byte read
	assign dmem_rdata = dmem_re ? mem[dmem_addr[9:0]] : ~last_q;
	always @(posedge clock) begin
		if (dmem_re) last_q <= mem[dmem_addr[9:0]];
		if (dmem_we) mem[dmem_addr[9:0]] <= dmem_wdata;
	end
endmodule

// ---- dv/tb_cpu_core_state_datapath.sv ----
// self-checking bench of the core state datapath
`timescale 1ns/10ps
module tb_cpu_core_state_datapath;
	logic clock, rst, instr_valid, busy, dmem_we, dmem_re, io_we, io_re, irq_ack;
	logic [15:0] prog_addr, prog_data, instr_word, instr_pc, target, dmem_addr, stack_pointer;
	logic [15:0] io_seen, ack_seen, s, p;
	logic [7:0] imm, dmem_wdata, dmem_rdata, io_wdata, io_rdata, status_flags_register;
	logic [5:0] io_addr;
	logic [4:0] rd_idx, rr_idx, irq_ack_idx;
	logic [2:0] bit_sel;
	logic [1:0] ptr_sel;
	logic [19:0] irq_req;
	core_pkg::op_t op;
	core_pkg::ptr_mode_t ptr_mode;
	int error_cnt, cmp_count, cyc;
	cpu_core_state_datapath dut (.clock, .rst, .prog_addr, .prog_data, .instr_word, .instr_pc, .instr_valid,
		.busy, .op, .rd_idx, .rr_idx, .imm, .bit_sel, .ptr_sel, .ptr_mode, .target, .dmem_addr, .dmem_wdata,
		.dmem_we, .dmem_re, .dmem_rdata, .io_addr, .io_wdata, .io_we, .io_re, .io_rdata, .irq_req, .irq_ack,
		.irq_ack_idx, .status_flags_register, .stack_pointer);
	core_mem_model mdl (.clock, .prog_addr, .prog_data, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re,
		.dmem_rdata);
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (io_we === 1'b1) io_seen <= {2'b00, io_addr, io_wdata};
		if (irq_ack === 1'b1) ack_seen <= {11'h000, irq_ack_idx};
		if (cyc == 3000) begin
			error_cnt++;
			complete_run();
		end
	end
	task complete_run;
		$display("errors %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wait_ready;
		int n;
		n = 0;
		while (!(instr_valid === 1'b1 && busy === 1'b0) && n < 20) begin
			@(negedge clock);
			n++;
		end
		if (n == 20) error_cnt++;
	endtask
	task ex(input core_pkg::op_t o, input logic [4:0] d, input logic [4:0] r, input logic [7:0] i);
		wait_ready();
		op = o;
		rd_idx = d;
		rr_idx = r;
		imm = i;
		bit_sel = i[2:0];
		target = {8'h00, i};
		@(negedge clock);
		op = core_pkg::OP_NOP;
		@(negedge clock);
	endtask
	// push a register and compare the byte landed in sram
	task preg(input logic [4:0] r, input logic [7:0] e);
		logic [15:0] a;
		wait_ready();
		a = stack_pointer;
		ex(core_pkg::OP_PUSH, r, r, 8'h00);
		chk({8'h00, mdl.mem[a[9:0]]}, {8'h00, e});
	endtask
	initial begin
		rst = 1'b1;
		op = core_pkg::OP_NOP;
		rd_idx = 5'h00;
		rr_idx = 5'h00;
		imm = 8'h00;
		bit_sel = 3'h0;
		ptr_sel = 2'h0;
		ptr_mode = core_pkg::PTR_POSTINC;
		target = 16'h0000;
		io_rdata = 8'h5a;
		irq_req = 20'h00000;
		repeat (2) @(negedge clock);
		chk(stack_pointer, 16'h0000);
		chk({8'h00, status_flags_register}, 16'h0000);
		rst = 1'b0;
		ex(core_pkg::OP_LDI, 5'd18, 5'd18, 8'h00);
		ex(core_pkg::OP_OUT, 5'd18, 5'd18, 8'h3d);
		ex(core_pkg::OP_LDI, 5'd19, 5'd19, 8'h01);
		ex(core_pkg::OP_OUT, 5'd19, 5'd19, 8'h3e);
		chk(stack_pointer, 16'h0100);
		ex(core_pkg::OP_LDI, 5'd16, 5'd16, 8'h7f);
		ex(core_pkg::OP_LDI, 5'd17, 5'd17, 8'h01);
		ex(core_pkg::OP_ADD, 5'd16, 5'd17, 8'h00);
		chk({8'h00, status_flags_register}, 16'h002c);
		ex(core_pkg::OP_LDI, 5'd17, 5'd17, 8'h80);
		ex(core_pkg::OP_ADD, 5'd17, 5'd16, 8'h00);
		chk({8'h00, status_flags_register}, 16'h001b);
		preg(5'd16, 8'h80);
		chk(stack_pointer, 16'h00ff);
		ex(core_pkg::OP_POP, 5'd20, 5'd20, 8'h00);
		chk(stack_pointer, 16'h0100);
		preg(5'd20, 8'h80);
		ex(core_pkg::OP_LDI, 5'd26, 5'd26, 8'h05);
		ex(core_pkg::OP_LDI, 5'd27, 5'd27, 8'h00);
		ex(core_pkg::OP_ST, 5'd16, 5'd16, 8'h00);
		preg(5'd5, 8'h80);
		preg(5'd26, 8'h06);
		ex(core_pkg::OP_LDI, 5'd26, 5'd26, 8'h25);
		ex(core_pkg::OP_ST, 5'd16, 5'd16, 8'h00);
		chk(io_seen, 16'h0580);
		ex(core_pkg::OP_IN, 5'd22, 5'd22, 8'h07);
		preg(5'd22, 8'h5a);
		ex(core_pkg::OP_BIT_STORE, 5'd16, 5'd16, 8'h07);
		chk({15'h0000, status_flags_register[6]}, 16'h0001);
		ex(core_pkg::OP_BIT_LOAD, 5'd23, 5'd23, 8'h02);
		preg(5'd23, 8'h04);
		wait_ready();
		s = stack_pointer;
		p = instr_pc + 16'h0001;
		ex(core_pkg::OP_CALL, 5'd0, 5'd0, 8'h40);
		wait_ready();
		chk(instr_pc, 16'h0040);
		chk(instr_word, ~16'h0040);
		chk(stack_pointer, s - 16'h0002);
		chk({mdl.mem[s[9:0] - 10'h001], mdl.mem[s[9:0]]}, p);
		ex(core_pkg::OP_RET, 5'd0, 5'd0, 8'h00);
		wait_ready();
		chk(stack_pointer, s);
		chk(instr_pc, p);
		ex(core_pkg::OP_SEI, 5'd0, 5'd0, 8'h00);
		chk({8'h00, status_flags_register}, 16'h00db);
		p = instr_pc;
		irq_req = 20'h00028;
		@(negedge clock);
		irq_req = 20'h00000;
		wait_ready();
		chk(ack_seen, 16'h0003);
		chk(instr_pc, 16'h0008);
		chk({8'h00, status_flags_register}, 16'h005b);
		ex(core_pkg::OP_IRQ_RETURN, 5'd0, 5'd0, 8'h00);
		wait_ready();
		chk({8'h00, status_flags_register}, 16'h00db);
		chk(instr_pc, p);
		ex(core_pkg::OP_CLI, 5'd0, 5'd0, 8'h00);
		ex(core_pkg::OP_LDI, 5'd16, 5'd16, 8'h10);
		ex(core_pkg::OP_LDI, 5'd17, 5'd17, 8'h20);
		ex(core_pkg::OP_SUB, 5'd16, 5'd17, 8'h00);
		chk({8'h00, status_flags_register}, 16'h0055);
		ex(core_pkg::OP_MOVW, 5'd24, 5'd16, 8'h00);
		preg(5'd25, 8'h20);
		ex(core_pkg::OP_LDI, 5'd26, 5'd26, 8'h11);
		ptr_mode = core_pkg::PTR_PREDEC;
		ex(core_pkg::OP_LD, 5'd21, 5'd21, 8'h00);
		preg(5'd21, 8'hf0);
		preg(5'd26, 8'h10);
		ex(core_pkg::OP_JMP, 5'd0, 5'd0, 8'h70);
		wait_ready();
		chk(instr_pc, 16'h0070);
		complete_run();
	end
endmodule
